// File: rtl/radio_seq_pkg.sv
// Constants and types for the radio operation sequencer
package radio_seq_pkg;

    // ------------------------------------------------------------
    // Clock and interval times
    // ------------------------------------------------------------
    localparam int CLK_FREQ_MHZ = 200;
    localparam int WARMUP_US    = 144;
    localparam int CCA_US       = 134;
    localparam int ED_US        = 198;
    localparam int BYTE_US      = 32;
    localparam int WARMDOWN_US  = 10;
    localparam int WARMUP_CYC   = WARMUP_US * CLK_FREQ_MHZ;
    localparam int CCA_CYC      = CCA_US * CLK_FREQ_MHZ;
    localparam int ED_CYC       = ED_US * CLK_FREQ_MHZ;
    localparam int BYTE_CYC     = BYTE_US * CLK_FREQ_MHZ;
    localparam int WARMDOWN_CYC = WARMDOWN_US * CLK_FREQ_MHZ;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int PREAMBLE_BYTES = 4;
    localparam int SFD_BYTES      = 1;
    localparam int LEN_BYTES      = 1;
    localparam int FCS_BYTES      = 2;
    localparam int OVERHEAD_BYTES = PREAMBLE_BYTES + SFD_BYTES + LEN_BYTES + FCS_BYTES;
    localparam int MAX_PAYLOAD    = 125;
    localparam int LEN_W          = 7;
    localparam int BYTE_IDX_W     = 8;
    localparam int TIMER_W        = 16;
    localparam logic [BYTE_IDX_W-1:0] BYTE_IDX_RST = 8'h00;

    typedef enum logic [1:0] {
        OP_CCA = 2'h0,
        OP_ED  = 2'h1,
        OP_RX  = 2'h2,
        OP_TX  = 2'h3
    } op_t;

    typedef enum logic [5:0] {
        ST_IDLE     = 6'h01,
        ST_WARMUP   = 6'h02,
        ST_MEASURE  = 6'h04,
        ST_LISTEN   = 6'h08,
        ST_TRANSMIT = 6'h10,
        ST_WARMDOWN = 6'h20
    } state_t;

endpackage

// File: rtl/seq_timer_if.sv
// Control link between the sequencer and its interval timer
`timescale 1ns/10ps
interface seq_timer_if #(parameter int W = 16);
    logic         load;
    logic [W-1:0] load_val;
    logic         stop;
    logic         expire;
    modport ctrl  (output load, output load_val, output stop, input expire);
    modport timer (input load, input load_val, input stop, output expire);
endinterface

// File: rtl/interval_timer.sv
// Down-counting interval timer, expires N cycles after a load of N
`timescale 1ns/10ps
module interval_timer
    import radio_seq_pkg::*;
#(
    parameter int W = TIMER_W
)(
    input  wire logic i_clock,
    input  wire logic i_sys_rst,
    seq_timer_if.timer tmr
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic         run_reg;
    logic         run_next;

    assign tmr.expire = run_reg && (cnt_reg == '0);

    always_comb
    begin
        cnt_next = cnt_reg;
        run_next = run_reg;
        if (tmr.load)
        begin
            cnt_next = tmr.load_val - W'(1);
            run_next = 1'b1;
        end
        else if (tmr.stop || tmr.expire)
        begin
            run_next = 1'b0;
        end
        else if (run_reg)
        begin
            cnt_next = cnt_reg - W'(1);
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            run_reg <= run_next;
        end
    end
endmodule

// File: rtl/radio_sequence_timing_control.sv
// Sequencer for channel assessment, receive and transmit radio operations
// Contract
// RULE_01: Rest in idle, start and end there
// RULE_02: Support CCA, energy detect, receive, transmit
// RULE_03: Assessment starts with 144 us warm-up
// RULE_04: Measure 134 or 198 us, then idle
// RULE_05: Receive: warm-up, then open-ended listening
// RULE_06: Receive ends on frame end or abort
// RULE_07: Transmit starts with 144 us warm-up
// RULE_08: Each transmitted byte takes 32 us
// RULE_09: Frame: 4 preamble, SFD, length, payload, 2 FCS
// RULE_10: Air time is 256 us plus 32 us/byte
// RULE_11: After last FCS byte, 10 us warm-down
// RULE_12: Host starts each operation separately
// RULE_13: Host sequences assess, transmit, then receive
// RULE_14: Host controls state and low power
// RULE_15: Intervals timed by clock-derived cycle counters
`timescale 1ns/10ps
module radio_sequence_timing_control
    import radio_seq_pkg::*;
#(
    parameter int WARM_CYC = WARMUP_CYC,
    parameter int CCA_LEN  = CCA_CYC,
    parameter int ED_LEN   = ED_CYC,
    parameter int BYTE_LEN = BYTE_CYC
)(
    input  wire logic                  i_clock,
    input  wire logic                  i_sys_rst,
    input  wire logic                  i_start,
    input  wire logic [1:0]            i_op,
    input  wire logic [LEN_W-1:0]      i_tx_len,
    input  wire logic                  i_abort,
    input  wire logic                  i_rx_frame_end,
    output logic [5:0]                 o_state,
    output logic                       o_busy,
    output logic                       o_rx_on,
    output logic                       o_tx_on,
    output logic                       o_byte_tick,
    output logic [BYTE_IDX_W-1:0]      o_byte_index,
    output logic                       o_done,
    output logic                       o_aborted
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    state_t                  state_reg,   state_next;
    op_t                     op_reg,      op_next;
    logic [BYTE_IDX_W-1:0]   total_reg,   total_next;
    logic [BYTE_IDX_W-1:0]   byte_reg,    byte_next;
    logic                    tx_abt_reg,  tx_abt_next;
    logic                    tick_next;
    logic                    done_next;
    logic                    abt_next;
    logic [LEN_W-1:0]        len_clamped;
    int                      age_reg,     age_next;

    seq_timer_if #(.W(TIMER_W)) tmr ();
    interval_timer #(.W(TIMER_W)) u_timer (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .tmr       (tmr.timer)
    );

    assign len_clamped = (i_tx_len > LEN_W'(MAX_PAYLOAD)) ? LEN_W'(MAX_PAYLOAD) : i_tx_len;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        state_next   = state_reg;
        op_next      = op_reg;
        total_next   = total_reg;
        byte_next    = byte_reg;
        tx_abt_next  = tx_abt_reg;
        tick_next    = 1'b0;
        done_next    = 1'b0;
        abt_next     = 1'b0;
        tmr.load     = 1'b0;
        tmr.load_val = '0;
        tmr.stop     = 1'b0;
        case (state_reg)
            ST_IDLE:
            begin
                if (i_start) // [RULE_01] [RULE_12]
                begin
                    op_next      = op_t'(i_op); // [RULE_02]
                    total_next   = BYTE_IDX_W'(OVERHEAD_BYTES) + {1'b0, len_clamped}; // [RULE_09]
                    tx_abt_next  = 1'b0;
                    state_next   = ST_WARMUP;
                    tmr.load     = 1'b1;
                    tmr.load_val = TIMER_W'(WARM_CYC); // [RULE_03] [RULE_05] [RULE_07] [RULE_15]
                end
            end
            ST_WARMUP:
            begin
                if (i_abort)
                begin
                    tmr.stop   = 1'b1;
                    abt_next   = 1'b1;
                    state_next = ST_IDLE;
                end
                else if (tmr.expire)
                begin
                    case (op_reg)
                        OP_CCA:
                        begin
                            state_next   = ST_MEASURE;
                            tmr.load     = 1'b1;
                            tmr.load_val = TIMER_W'(CCA_LEN); // [RULE_04]
                        end
                        OP_ED:
                        begin
                            state_next   = ST_MEASURE;
                            tmr.load     = 1'b1;
                            tmr.load_val = TIMER_W'(ED_LEN); // [RULE_04]
                        end
                        OP_RX:
                            state_next = ST_LISTEN; // [RULE_05]
                        default:
                        begin
                            state_next   = ST_TRANSMIT;
                            byte_next    = BYTE_IDX_RST;
                            tick_next    = 1'b1;
                            tmr.load     = 1'b1;
                            tmr.load_val = TIMER_W'(BYTE_LEN); // [RULE_08]
                        end
                    endcase
                end
            end
            ST_MEASURE:
            begin
                if (i_abort)
                begin
                    tmr.stop   = 1'b1;
                    abt_next   = 1'b1;
                    state_next = ST_IDLE;
                end
                else if (tmr.expire)
                begin
                    done_next  = 1'b1;
                    state_next = ST_IDLE; // [RULE_04]
                end
            end
            ST_LISTEN:
            begin
                // Frame end wins over a simultaneous abort
                if (i_rx_frame_end) // [RULE_06]
                begin
                    done_next  = 1'b1;
                    state_next = ST_IDLE;
                end
                else if (i_abort) // [RULE_06]
                begin
                    abt_next   = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            ST_TRANSMIT:
            begin
                // Abort still tapers the transmitter off
                if (i_abort)
                begin
                    abt_next     = 1'b1;
                    tx_abt_next  = 1'b1;
                    state_next   = ST_WARMDOWN;
                    tmr.load     = 1'b1;
                    tmr.load_val = TIMER_W'(WARMDOWN_CYC);
                end
                else if (tmr.expire)
                begin
                    if (byte_reg == total_reg - BYTE_IDX_W'(1)) // [RULE_10] [RULE_11]
                    begin
                        state_next   = ST_WARMDOWN;
                        tmr.load     = 1'b1;
                        tmr.load_val = TIMER_W'(WARMDOWN_CYC); // [RULE_11]
                    end
                    else
                    begin
                        byte_next    = byte_reg + BYTE_IDX_W'(1);
                        tick_next    = 1'b1;
                        tmr.load     = 1'b1;
                        tmr.load_val = TIMER_W'(BYTE_LEN); // [RULE_08]
                    end
                end
            end
            ST_WARMDOWN:
            begin
                if (tmr.expire)
                begin
                    done_next  = !tx_abt_reg;
                    state_next = ST_IDLE; // [RULE_01]
                end
            end
            default:
            begin
                tmr.stop   = 1'b1;
                state_next = ST_IDLE;
            end
        endcase
        age_next = (state_next != state_reg) ? 0 : age_reg + 1;
    end

    // ------------------------------------------------------------
    // Registers and registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            state_reg    <= ST_IDLE;
            op_reg       <= OP_CCA;
            total_reg    <= BYTE_IDX_RST;
            byte_reg     <= BYTE_IDX_RST;
            tx_abt_reg   <= 1'b0;
            o_state      <= ST_IDLE;
            o_busy       <= 1'b0;
            o_rx_on      <= 1'b0;
            o_tx_on      <= 1'b0;
            o_byte_tick  <= 1'b0;
            o_byte_index <= BYTE_IDX_RST;
            o_done       <= 1'b0;
            o_aborted    <= 1'b0;
            age_reg      <= 0;
        end
        else
        begin
            state_reg    <= state_next;
            op_reg       <= op_next;
            total_reg    <= total_next;
            byte_reg     <= byte_next;
            tx_abt_reg   <= tx_abt_next;
            o_state      <= state_next;
            o_busy       <= (state_next != ST_IDLE);
            o_rx_on      <= (state_next == ST_MEASURE) || (state_next == ST_LISTEN);
            o_tx_on      <= (state_next == ST_TRANSMIT);
            o_byte_tick  <= tick_next;
            o_byte_index <= byte_next;
            o_done       <= done_next;
            o_aborted    <= abt_next;
            age_reg      <= age_next;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    sequence s_idle_start;
        state_reg == ST_IDLE && i_start;
    endsequence
    sequence s_warm_enter;
        state_reg == ST_WARMUP && o_busy && !o_rx_on && !o_tx_on;
    endsequence
    property p_start_warm;
        s_idle_start |=> s_warm_enter;
    endproperty
    a_start_warm: assert property (p_start_warm) else $error("start did not warm up"); // [RULE_01]
    property p_warm_len;
        (state_reg == ST_WARMUP && state_next != ST_WARMUP && state_next != ST_IDLE)
            |-> age_reg == WARM_CYC - 1;
    endproperty
    a_warm_len: assert property (p_warm_len) else $error("warm-up length wrong"); // [RULE_03]
    property p_meas_len;
        (state_reg == ST_MEASURE && state_next == ST_IDLE && !i_abort)
            |-> age_reg == ((op_reg == OP_ED) ? ED_LEN : CCA_LEN) - 1;
    endproperty
    a_meas_len: assert property (p_meas_len) else $error("measure length wrong"); // [RULE_04]
    property p_rx_next;
        (state_reg == ST_WARMUP && op_reg == OP_RX && state_next != ST_WARMUP && !i_abort)
            |=> state_reg == ST_LISTEN && o_rx_on;
    endproperty
    a_rx_next: assert property (p_rx_next) else $error("receive did not listen"); // [RULE_05]
    property p_rx_end;
        (state_reg == ST_LISTEN && i_rx_frame_end) |=> state_reg == ST_IDLE && o_done ##1 !o_done;
    endproperty
    a_rx_end: assert property (p_rx_end) else $error("frame end did not finish"); // [RULE_06]
    property p_tx_time;
        (state_reg == ST_TRANSMIT && state_next == ST_WARMDOWN && !i_abort)
            |-> age_reg == int'(total_reg) * BYTE_LEN - 1 && byte_reg == total_reg - 8'h01;
    endproperty
    a_tx_time: assert property (p_tx_time) else $error("transmit air time wrong"); // [RULE_10]
    property p_tx_tick;
        (state_reg == ST_TRANSMIT && tmr.expire && !i_abort && state_next == ST_TRANSMIT)
            |=> o_byte_tick && o_byte_index == $past(byte_reg) + 8'h01;
    endproperty
    a_tx_tick: assert property (p_tx_tick) else $error("byte tick missing"); // [RULE_08]
    property p_frame_bytes;
        (state_reg == ST_IDLE && i_start) |=> total_reg >= 8'(OVERHEAD_BYTES)
            && total_reg <= 8'(OVERHEAD_BYTES + MAX_PAYLOAD);
    endproperty
    a_frame_bytes: assert property (p_frame_bytes) else $error("frame size out of range"); // [RULE_09]
    property p_warmdown;
        (state_reg == ST_WARMDOWN && state_next == ST_IDLE)
            |-> age_reg == WARMDOWN_CYC - 1 && !o_tx_on;
    endproperty
    a_warmdown: assert property (p_warmdown) else $error("warm-down length wrong"); // [RULE_11]
endmodule

// File: tb/radio_host_model.sv
// Host-side model that programs and starts sequencer operations
`timescale 1ns/10ps
module radio_host_model (
    input  wire logic       i_clock,
    input  wire logic [5:0] i_state,
    input  wire logic       i_go,
    input  wire logic       i_force,
    input  wire logic [1:0] i_op_req,
    input  wire logic [6:0] i_len_req,
    output logic            o_start,
    output logic [1:0]      o_op,
    output logic [6:0]      o_tx_len
);
    initial
    begin
        o_start  = 1'b0;
        o_op     = 2'h0;
        o_tx_len = 7'h00;
    end

    // ------------------------------------------------------------
    // One start pulse per request, only from idle unless forced
    // ------------------------------------------------------------
    always @(negedge i_clock)
    begin
        o_start  <= i_go && ((i_state === 6'h01) || i_force);
        o_op     <= i_op_req;
        o_tx_len <= i_len_req;
    end
endmodule

// File: tb/test_radio_sequence_timing_control.sv
// Self-checking bench for the radio operation sequencer
`timescale 1ns/10ps
module test_radio_sequence_timing_control;
    import radio_seq_pkg::*;
    localparam int W  = 20;
    localparam int CL = 15;
    localparam int EL = 25;
    localparam int B  = 8;
    localparam int WD = WARMDOWN_CYC;

    logic        i_clock;
    logic        i_sys_rst;
    logic        go;
    logic        frc;
    logic        abort;
    logic        fe_in;
    logic [1:0]  op_req;
    logic [6:0]  len_req;
    logic [6:0]  tx_l;
    logic        start;
    logic [1:0]  op;
    logic [6:0]  txlen;
    logic [5:0]  o_state;
    logic        o_busy;
    logic        o_rx_on;
    logic        o_tx_on;
    logic        o_byte_tick;
    logic [7:0]  o_byte_index;
    logic        o_done;
    logic        o_aborted;
    logic [15:0] lfsr;
    logic [7:0]  r_st;
    logic        r_dn;
    logic        r_ab;
    int          r_on;
    int          r_wd;
    int          r_end;
    int          r_ticks;
    int          fails;
    int          samples_checked;

    radio_host_model i_radio_host_model (
        .i_clock(i_clock), .i_state(o_state), .i_go(go), .i_force(frc),
        .i_op_req(op_req), .i_len_req(len_req), .o_start(start), .o_op(op),
        .o_tx_len(txlen)
    );

    radio_sequence_timing_control #(.WARM_CYC(W), .CCA_LEN(CL), .ED_LEN(EL), .BYTE_LEN(B))
    i_radio_sequence_timing_control (
        .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_start(start), .i_op(op),
        .i_tx_len(txlen), .i_abort(abort), .i_rx_frame_end(fe_in),
        .o_state(o_state), .o_busy(o_busy), .o_rx_on(o_rx_on), .o_tx_on(o_tx_on),
        .o_byte_tick(o_byte_tick), .o_byte_index(o_byte_index), .o_done(o_done),
        .o_aborted(o_aborted)
    );

    initial
    begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end

    // ------------------------------------------------------------
    // Expectations and checks
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    function automatic int nbytes(input int len);
        return 8 + ((len > 125) ? 125 : len);
    endfunction

    function automatic int exp_end(input int o);
        return W + 1 + ((o == 0) ? CL : EL);
    endfunction

    task automatic end_sim;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk_cnt(input string n, input int e, input int g);
        samples_checked++;
        if (e != g)
        begin
            fails++;
            $display("ERROR %s expected %0d seen %0d", n, e, g);
        end
    endtask

    task automatic chk_val(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    // One operation from idle back to idle, with optional events
    task automatic run(input logic [1:0] o, input logic [6:0] len, input int fe, input int ab,
                       input int st);
        int k;
        int last;
        go      <= 1'b1;
        frc     <= 1'b0;
        op_req  <= o;
        len_req <= len;
        @(negedge i_clock);
        go <= 1'b0;
        {r_on, r_wd, r_end, r_ticks, r_dn, r_ab, last} = '0;
        r_st = 8'h00;
        for (k = 1; k <= 4000 && r_end == 0; k++)
        begin
            @(negedge i_clock);
            go    <= (k == st);
            frc   <= (k == st);
            abort <= (k == ab);
            fe_in <= (k == fe);
            if (k == 1)
                chk_val("start_answer", 8'h42, {1'b0, o_busy, o_state});
            if ((o_rx_on === 1'b1 || o_tx_on === 1'b1) && r_on == 0)
            begin
                r_on = k;
                r_st = {o_tx_on, o_rx_on, o_state};
            end
            if (o_byte_tick === 1'b1)
            begin
                chk_val("byte_index", r_ticks[7:0], o_byte_index);
                if (r_ticks > 0)
                    chk_cnt("byte_gap", B, k - last);
                last = k;
                r_ticks++;
            end
            if (o_state === 6'h20 && r_wd == 0)
                r_wd = k;
            if (o_aborted === 1'b1)
                r_ab = 1'b1;
            if (o_state === 6'h01)
            begin
                r_end = k;
                r_dn  = o_done;
                chk_val("end_busy", 8'h00, {7'h00, o_busy});
            end
        end
        if (r_end == 0)
        begin
            fails++;
            return;
        end
        @(negedge i_clock);
        chk_val("done_pulse", 8'h00, {7'h00, o_done});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {i_sys_rst, go, frc, abort, fe_in} = 5'b10000;
        op_req          = 2'h0;
        len_req         = 7'h00;
        lfsr            = 16'h606E;
        fails           = 0;
        samples_checked = 0;
        repeat (3) @(posedge i_clock);
        @(negedge i_clock);
        i_sys_rst <= 1'b0;
        chk_val("reset_state", 8'h01, {2'b00, o_state});
        chk_val("reset_busy", 8'h00, {7'h00, o_busy});
        for (int o = 0; o < 2; o++)
        begin
            run(o[1:0], 7'h00, 0, 0, 0);
            chk_cnt("meas_start", W + 1, r_on);
            chk_val("meas_state", 8'h44, r_st);
            chk_cnt("meas_end", exp_end(o), r_end);
            chk_val("meas_done", 8'h01, {7'h00, r_dn});
        end
        lfsr = lfsr_next(lfsr);
        run(2'h2, 7'h00, W + 2 + lfsr[5:0], 0, 0);
        chk_cnt("rx_start", W + 1, r_on);
        chk_val("rx_state", 8'h48, r_st);
        chk_cnt("rx_end", W + 3 + lfsr[5:0], r_end);
        chk_val("rx_done", 8'h01, {7'h00, r_dn});
        lfsr = lfsr_next(lfsr);
        run(2'h2, 7'h00, 0, W + 2 + lfsr[5:0], 0);
        chk_cnt("rx_abort_end", W + 3 + lfsr[5:0], r_end);
        chk_val("rx_aborted", 8'h01, {7'h00, r_ab});
        chk_val("rx_abort_done", 8'h00, {7'h00, r_dn});
        run(2'h0, 7'h00, 0, 5, 0);
        chk_cnt("warm_abort_end", 6, r_end);
        chk_val("warm_aborted", 8'h01, {7'h00, r_ab});
        for (int i = 0; i < 5; i++)
        begin
            lfsr = lfsr_next(lfsr);
            tx_l = (i == 0) ? 7'h00 : (i == 1) ? 7'h7D : (i == 2) ? 7'h7F : 7'(lfsr % 126);
            // Last pass also aborts during warm-down, which must be ignored
            run(2'h3, tx_l, (i == 4) ? W + 10 : 0, (i == 4) ? W + 5 + nbytes(tx_l) * B : 0,
                (i == 3) ? 3 : 0);
            chk_cnt("tx_start", W + 1, r_on);
            chk_val("tx_state", 8'h90, r_st);
            chk_cnt("tx_bytes", nbytes(tx_l), r_ticks);
            chk_cnt("tx_air", W + 1 + nbytes(tx_l) * B, r_wd);
            chk_cnt("tx_warmdown", WD, r_end - r_wd);
            chk_val("tx_done", 8'h01, {7'h00, r_dn});
            chk_val("tx_no_abort", 8'h00, {7'h00, r_ab});
        end
        run(2'h3, 7'h04, 0, W + 12, 0);
        chk_val("tx_aborted", 8'h01, {7'h00, r_ab});
        chk_val("tx_abort_done", 8'h00, {7'h00, r_dn});
        chk_cnt("tx_abort_warmdown", WD, r_end - r_wd);
        // Reset in the middle of a transmission
        go     <= 1'b1;
        op_req <= 2'h3;
        @(negedge i_clock);
        go <= 1'b0;
        repeat (W + 4) @(negedge i_clock);
        chk_val("mid_tx_on", 8'h01, {7'h00, o_tx_on});
        i_sys_rst <= 1'b1;
        @(negedge i_clock);
        chk_val("mid_rst_state", 8'h01, {2'b00, o_state});
        chk_val("mid_rst_outputs", 8'h00, {5'h00, o_busy, o_tx_on, o_byte_tick});
        i_sys_rst <= 1'b0;
        // Assess, send, then listen for the reply
        run(2'h0, 7'h00, 0, 0, 0);
        chk_val("seq_cca_done", 8'h01, {7'h00, r_dn});
        run(2'h3, 7'h01, 0, 0, 0);
        chk_cnt("seq_tx_air", W + 1 + nbytes(1) * B, r_wd);
        run(2'h2, 7'h00, W + 4, 0, 0);
        chk_cnt("seq_rx_end", W + 5, r_end);
        chk_val("seq_rx_done", 8'h01, {7'h00, r_dn});
        end_sim();
    end
endmodule
